// [dv/rlls_afe_model.sv]
// behavioural analog front end: lock, detect, serial line, recovered clock
// assumes the bench drives its commands right after rising edges
module rlls_afe_model (
   // commands from the bench
   input  wire logic       clk_i,
   input  wire logic [2:0] fault_i,
   input  wire logic       hold_line_i,
   input  wire logic       clk_run_i,
   // levels toward the bank
   output logic            ref_lock_lost_o,
   output logic            freq_err_o,
   output logic            rx_serial_o = 1'b0,
   output logic            recovered_clk_o = 1'b0,
   output logic            signal_detect_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // fault levels per status cause
   assign ref_lock_lost_o = fault_i[0];
   assign freq_err_o      = fault_i[1];
   assign signal_detect_o = !fault_i[2];
   // line toggles unless a run is held; clock only while running
   always @(posedge clk_i) begin
      if (!hold_line_i) rx_serial_o <= ~rx_serial_o;
      if (clk_run_i) recovered_clk_o <= ~recovered_clk_o;
   end
endmodule

// [dv/rlls_checker_properties.sv]
// checker for the lock status bank, bound to the top module
// assumes the waitrequest handshake and registered control outputs
module rlls_checker #(
   parameter AW = 8
) (
   // clock, reset and register bus
   input wire          clk_i,
   input wire          rstn_i,
   input wire [AW-1:0] avs_address_i,
   input wire          avs_read_i,
   input wire          avs_write_i,
   input wire [31:0]   avs_writedata_i,
   input wire [3:0]    avs_byteenable_i,
   input wire [31:0]   avs_readdata_o,
   input wire          avs_waitrequest_o,
   // front end controls
   input wire          irq_o,
   input wire          detect_active_o,
   input wire          train_to_ref_o,
   input wire          serial_diag_loopback_o,
   input wire          slice_one_rx_enable_o,
   input wire          recovery_unit_enable_o,
   input wire          recovery_unit_reset_o,
   input wire          slice_one_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   reg  [1:0] rcnt_reg;
   wire       alive = (rcnt_reg == 2'h3);
   wire       acc_w = avs_write_i && !avs_waitrequest_o;
   wire       wr21  = acc_w && (avs_address_i == 8'h21);
   wire       wr22  = acc_w && (avs_address_i == 8'h22);
   // cycles since reset release, saturating
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) rcnt_reg <= 2'h0;
      else if (!alive) rcnt_reg <= rcnt_reg + 2'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ******************************************
   // properties
   // ******************************************
   wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   wait_answer_a: assert property (alive && (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("request not answered next cycle");
   irq_mask_a: assert property (wr21 && avs_byteenable_i[0] && avs_writedata_i[2:0] == 3'h0
      |-> ##2 !irq_o [*3]) else $error("irq high with all enables off");
   detect_mask_a: assert property (wr21 && avs_byteenable_i[1] && avs_writedata_i[15]
      |-> ##[2:3] detect_active_o) else $error("mask did not force detect");
   loop_copy_a: assert property (wr22 && avs_byteenable_i[0]
      |-> ##2 serial_diag_loopback_o == $past(avs_writedata_i[7], 2)) else $error("loopback bad");
   reset_excl_a: assert property (recovery_unit_reset_o |-> !recovery_unit_enable_o)
      else $error("recovery enabled while in reset");
   reset_hold_a: assert property (alive && $changed(recovery_unit_reset_o)
      |-> $past(wr22, 1) || $past(wr22, 2)) else $error("recovery reset changed alone");
   slice_gate_a: assert property (slice_one_data_o |-> slice_one_rx_enable_o)
      else $error("slice data while slice disabled");
   train_follow_a: assert property (alive |-> train_to_ref_o != detect_active_o)
      else $error("training not opposite of detect");
   unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o
      && (avs_address_i < 8'h1f || avs_address_i > 8'h23) |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   c_irq: cover property (irq_o);
   c_mask: cover property (wr21 && avs_writedata_i[15]);
   c_rst: cover property ($rose(recovery_unit_reset_o));
endmodule

bind rlls_top rlls_checker #(.AW(AW)) rlls_checker_i (.clk_i(clk_i), .rstn_i(rstn_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
   .detect_active_o(detect_active_o), .train_to_ref_o(train_to_ref_o),
   .serial_diag_loopback_o(serial_diag_loopback_o),
   .slice_one_rx_enable_o(slice_one_rx_enable_o),
   .recovery_unit_enable_o(recovery_unit_enable_o),
   .recovery_unit_reset_o(recovery_unit_reset_o), .slice_one_data_o(slice_one_data_o));

// [dv/tb_top.sv]
// self-checking bench for the lock status bank
// assumes the afe model on the analog pins and bus answers within 50 cycles
`include "rlls_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] a_sts = `RLLS_IDX_STATUS, a_irq = `RLLS_IDX_IRQCTL;
   localparam logic [7:0] a_rec = `RLLS_IDX_RECCTL, a_scr = `RLLS_IDX_SCRATCH;
   localparam logic [7:0] a_trn = `RLLS_IDX_TRAINCFG;
   logic        clk_i = 0, rstn_i = 0, rd_i = 0, wr_i = 0, hold = 0, crun = 0;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, q, v;
   logic [3:0]  be = 0;
   logic [2:0]  fault = 0;
   wire  [31:0] rdat;
   wire         wreq, irq, det, trn, lpb, slc, ren, hren, rrst, rl, fe, rx, rc, sd, dll;
   int          err_count = 0, checks_done = 0, cyc = 0;
   rlls_top rlls_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
      .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ref_lock_lost_i(rl),
      .freq_err_i(fe), .rx_serial_i(rx), .recovered_clk_i(rc), .signal_detect_input_i(sd),
      .irq_o(irq), .detect_active_o(det), .train_to_ref_o(trn), .serial_diag_loopback_o(lpb),
      .slice_one_rx_enable_o(slc), .recovery_unit_enable_o(ren),
      .high_rate_receiver_enable_o(hren), .recovery_unit_reset_o(rrst),
      .slice_one_data_o(), .data_lock_lost_live_o(dll));
   rlls_afe_model rlls_afe_model_i (.clk_i(clk_i), .fault_i(fault), .hold_line_i(hold),
      .clk_run_i(crun), .ref_lock_lost_o(rl), .freq_err_o(fe), .rx_serial_o(rx),
      .recovered_clk_o(rc), .signal_detect_o(sd));
   // clock and hang limit
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   // ******************************************
   // tasks and expectations
   // ******************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      be <= b;
      wr_i <= w;
      rd_i <= !w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      if (n >= 50) err_count++;
      rd_i <= 0;
      wr_i <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'h3);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask
   // loopback, slice, receiver, recovery enable, recovery reset
   function automatic logic [4:0] ctl_exp(input logic [15:0] r);
      return {r[7], r[8], r[12], r[11] & ~r[14], r[14]};
   endfunction
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ******************************************
   // main sequence
   // ******************************************
   initial begin
      void'($urandom(16658));
      tick(8);
      rstn_i <= 1;
      tick(4);
      rd(a_sts); chk(q & 32'hc000, 32'hc000);
      rd(a_irq); chk(q, 32'h0);
      rd(a_scr); chk(q, 32'h0);
      rd(8'h40); chk(q, 32'h0);
      rd(a_rec); chk(q, 32'hb82b);
      chk(32'({lpb, slc, hren, ren, rrst}), 32'(ctl_exp(16'hb82b)));
      rd(a_trn); chk(q, 32'h441f);
      chk(dll, 0);
      repeat (4) begin
         v = $urandom;
         wr(a_scr, v);
         rd(a_scr); chk(q, {16'h0, v[15:0]});
      end
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hb9ab : (32'ha02b | ($urandom & 32'h5980));
         wr(a_rec, v);
         rd(a_rec); chk(q, v);
         chk(32'({lpb, slc, hren, ren, rrst}), 32'(ctl_exp(v[15:0])));
      end
      wr(a_rec, 32'hf82b);
      tick(1000);
      chk(ren, 0);
      wr(a_rec, 32'hb82b);
      tick(3);
      chk({rrst, ren}, 2'h1);
      for (int i = 0; i < 3; i++) begin
         rd(a_sts);
         wr(a_irq, 32'h1 << i);
         fault <= 3'h1 << i;
         tick(6); chk(irq, 1);
         fault <= 0;
         tick(6); chk(irq, 1);
         rd(a_sts); chk(q[i], 1);
         tick(4); chk(irq, 0);
      end
      wr(a_irq, 32'h0);
      fault <= 3'h7;
      tick(6); chk(irq, 0);
      fault <= 0;
      tick(6);
      rd(a_sts); chk(q[2:0], 3'h7);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, a_trn, {14'h0, m[1:0], 16'h440f}, 4'h7);
         fault <= 3'h1;
         tick(6);
         fault <= 0;
         tick(6);
         rd(a_sts);
         rd(a_sts); chk(q[0], m[0] ^ m[1]);
         wr(a_sts, 32'h0);
         rd(a_sts); chk(q[0], m[0] ^ m[1]);
         wr(a_sts, 32'h1);
         rd(a_sts); chk(q[0], 0);
      end
      rd(a_sts);
      hold <= 1;
      tick(90);
      rd(a_sts); chk(q[2:1], 2'h0);
      tick(60);
      rd(a_sts); chk(q[2:1], 2'h3);
      chk(dll, 1);
      hold <= 0;
      rd(a_sts); chk(q[15], 0);
      crun <= 1;
      tick(10);
      crun <= 0;
      tick(4);
      rd(a_sts); chk(q[15], 1);
      rd(a_sts); chk(q[15], 0);
      fault <= 3'h4;
      tick(6); chk({det, trn}, 2'h1);
      wr(a_irq, 32'h8000);
      tick(4); chk(det, 1);
      wr(a_irq, 32'h0);
      bus(1'b1, a_trn, 32'h3450f, 4'h7);
      tick(4); chk(det, 1);
      fault <= 0;
      tick(6); chk({det, trn}, 2'h1);
      print_verdict();
   end
endmodule

// [rtl/rlls_consts.vh]
// register offsets, field positions and reset values of the lock status bank
// assumes a 10 MHz register clock and a 16-bit data word in the low bits
//
// Functional notes
// - a sixteen-bit scratch register stores and returns any value, no side effects.
// - status bit 0 sets while the loop cannot lock to reference.
// - sticky bits clear by write-one when mode xor is 1, else by read.
// - status bit 1 sets on frequency error or long run without transitions; the code also sets it while internal detect is low.
// - five-bit loss count is upper five bits of a nine-bit threshold.
// - status bit 2 sets when detect is low or run threshold reached.
// - with detect low the unit trains to reference; data lock may toggle; the code holds data_lock_lost_live_o at 1 while detect is low.
// - status bit 15 sets on recovered clock edge, clears on status read.
// - enables at bits 2..0 gate their status bits onto the interrupt pin.
// - detect mask bit 15 forces internal detect active, else follows input.
// - loopback bit 7 routes transmit serial data into the receive path.
// - slice-one enable bit 8 resets to 0; when 1 serial input feeds slice one.
// - recovery enable bit 11, default 1, low-power when 0.
// - receiver enable bit 12, default 1, powers down receiver when 0.
// - recovery reset bit 14 holds the unit reset until software writes 0.
// - detect invert setting inverts detect input polarity before masking.
// - each loss-count unit stands for sixteen identical received bits.
`ifndef RLLS_CONSTS_VH
`define RLLS_CONSTS_VH

// ******************************************
// register indices, byte address is four times
// ******************************************
`define RLLS_IDX_SCRATCH   8'h1f
`define RLLS_IDX_STATUS    8'h20
`define RLLS_IDX_IRQCTL    8'h21
`define RLLS_IDX_RECCTL    8'h22
`define RLLS_IDX_TRAINCFG  8'h23

// ******************************************
// field positions
// ******************************************
`define RLLS_B_REF_LOCK    0
`define RLLS_B_DATA_LOCK   1
`define RLLS_B_SIG_LOSS    2
`define RLLS_B_CLK_ALIVE   15
`define RLLS_B_STS_RSV14   14
`define RLLS_B_DET_MASK    15
`define RLLS_B_LOOPBACK    7
`define RLLS_B_SLICE1      8
`define RLLS_B_REC_EN      11
`define RLLS_B_RX_EN       12
`define RLLS_B_REC_RST     14
`define RLLS_B_WCM_A       0
`define RLLS_B_WCM_B       1
`define RLLS_B_DET_INV     8
`define RLLS_B_LOSS_EN     10
`define RLLS_B_LCNT_LO     11
`define RLLS_B_LCNT_HI     15

// ******************************************
// reset values and masks
// ******************************************
`define RLLS_RST_SCRATCH   16'h0000
`define RLLS_RST_IRQCTL    16'h0000
`define RLLS_MSK_IRQCTL    16'h803f
`define RLLS_RST_RECCTL    16'hb82b
`define RLLS_RST_TRAINCFG  16'h440f
`define RLLS_MSK_TRAINCFG  16'hff8f
`define RLLS_RST_WCM       2'h0
`define RLLS_STS_RSV       16'h4000
`define RLLS_RUN_UNIT_LOG2 4

`endif

// [rtl/rlls_sync2.v]
// two-flop synchroniser for a vector of level inputs
// assumes inputs are quasi-static levels from another domain
module rlls_sync2 #(
   parameter W = 1
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rstn_i,
   // data
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // first stage only feeds second stage
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule

// [rtl/rlls_top.v]
// lock and signal status register bank with avalon-mm slave
// assumes analog status levels arrive asynchronously and pass a synchroniser
`include "rlls_consts.vh"
module rlls_top #(
   parameter AW = 8
) (
   // clock and reset
   input  wire          clk_i,
   input  wire          rstn_i,
   // avalon-mm slave (word address)
   input  wire [AW-1:0] avs_address_i,
   input  wire          avs_read_i,
   input  wire          avs_write_i,
   input  wire [31:0]   avs_writedata_i,
   input  wire [3:0]    avs_byteenable_i,
   output reg  [31:0]   avs_readdata_o,
   output reg           avs_waitrequest_o,
   // analog front end status
   input  wire          ref_lock_lost_i,
   input  wire          freq_err_i,
   input  wire          rx_serial_i,
   input  wire          recovered_clk_i,
   input  wire          signal_detect_input_i,
   // analog front end controls
   output reg           irq_o,
   output reg           detect_active_o,
   output reg           train_to_ref_o,
   output reg           serial_diag_loopback_o,
   output reg           slice_one_rx_enable_o,
   output reg           recovery_unit_enable_o,
   output reg           high_rate_receiver_enable_o,
   output reg           recovery_unit_reset_o,
   output reg           slice_one_data_o,
   output reg           data_lock_lost_live_o
);

   // ******************************************
   // reset release and input synchronisers
   // ******************************************
   reg        rst_meta_reg;
   reg        rst_sync_reg;
   wire       rst_n;
   wire [4:0] sync_q;
   wire       ref_lost_s;
   wire       freq_err_s;
   wire       rx_bit_s;
   wire       rclk_s;
   wire       sd_s;

   // two-flop reset release
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   rlls_sync2 #(
      .W (5)
   ) u_sync (
      .clk_i  (clk_i),
      .rstn_i (rst_n),
      .d_i    ({ref_lock_lost_i, freq_err_i, rx_serial_i, recovered_clk_i,
                signal_detect_input_i}),
      .q_o    (sync_q)
   );
   assign ref_lost_s = sync_q[4];
   assign freq_err_s = sync_q[3];
   assign rx_bit_s   = sync_q[2];
   assign rclk_s     = sync_q[1];
   assign sd_s       = sync_q[0];

   // ******************************************
   // registers
   // ******************************************
   reg  [15:0] scratch_reg;
   reg  [15:0] irqctl_reg;
   reg  [15:0] recctl_reg;
   reg  [15:0] traincfg_reg;
   reg  [1:0]  wcm_reg;
   reg  [2:0]  sticky_reg;
   reg  [2:0]  sticky_next;
   reg         alive_reg;
   reg         rclk_d_reg;
   reg         rx_d_reg;
   reg  [8:0]  run_reg;
   reg         run_hit_reg;
   reg         acc_reg;
   wire        rd_hit;
   wire        wr_hit;
   wire        wr_lo;
   wire        wr_hi;
   wire        clear_by_write;
   wire        det_raw;
   wire        det_int;
   wire [8:0]  run_limit;
   wire [2:0]  set_cond;
   wire [2:0]  clr_mask;
   reg  [15:0] rdata;

   // byte-lane merge of a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] nw;
      input        lo;
      input        hi;
      begin
         merge16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
      end
   endfunction

   // avalon access: one wait cycle, then answer
   assign wr_hit = avs_write_i && acc_reg;
   assign rd_hit = avs_read_i && acc_reg;
   assign wr_lo  = wr_hit && avs_byteenable_i[0];
   assign wr_hi  = wr_hit && avs_byteenable_i[1];

   // ******************************************
   // detect path and run-length loss
   // ******************************************
   assign det_raw = sd_s ^ traincfg_reg[`RLLS_B_DET_INV];
   assign det_int = irqctl_reg[`RLLS_B_DET_MASK] ? 1'b1 : det_raw;
   assign run_limit = {traincfg_reg[`RLLS_B_LCNT_HI:`RLLS_B_LCNT_LO],
                       {`RLLS_RUN_UNIT_LOG2{1'b0}}};

   // count consecutive identical received bits
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_d_reg    <= 1'b0;
         run_reg     <= 9'h000;
         run_hit_reg <= 1'b0;
      end else begin
         rx_d_reg <= rx_bit_s;
         if (rx_bit_s != rx_d_reg || !traincfg_reg[`RLLS_B_LOSS_EN]) begin
            run_reg     <= 9'h000;
            run_hit_reg <= 1'b0;
         end else begin
            if (run_reg != 9'h1ff)
               run_reg <= run_reg + 9'h001;
            run_hit_reg <= (run_reg >= run_limit);
         end
      end
   end

   // ******************************************
   // sticky status
   // ******************************************
   assign set_cond[`RLLS_B_REF_LOCK]  = ref_lost_s;
   assign set_cond[`RLLS_B_DATA_LOCK] = freq_err_s || run_hit_reg || !det_int;
   assign set_cond[`RLLS_B_SIG_LOSS]  = !det_int || run_hit_reg;
   assign clear_by_write = wcm_reg[`RLLS_B_WCM_A] ^ wcm_reg[`RLLS_B_WCM_B];
   assign clr_mask = (avs_address_i == `RLLS_IDX_STATUS) ?
                     (clear_by_write ? (wr_lo ? avs_writedata_i[2:0] : 3'h0)
                                     : (rd_hit ? 3'h7 : 3'h0)) : 3'h0;

   // set wins over clear
   always @* begin
      sticky_next = (sticky_reg & ~clr_mask) | set_cond;
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sticky_reg <= 3'h0;
         alive_reg  <= 1'b1;
         rclk_d_reg <= 1'b0;
      end else begin
         sticky_reg <= sticky_next;
         rclk_d_reg <= rclk_s;
         if (rclk_s && !rclk_d_reg)
            alive_reg <= 1'b1;
         else if (rd_hit && avs_address_i == `RLLS_IDX_STATUS)
            alive_reg <= 1'b0;
      end
   end

   // ******************************************
   // register writes
   // ******************************************
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scratch_reg  <= `RLLS_RST_SCRATCH;
         irqctl_reg   <= `RLLS_RST_IRQCTL;
         recctl_reg   <= `RLLS_RST_RECCTL;
         traincfg_reg <= `RLLS_RST_TRAINCFG;
         wcm_reg      <= `RLLS_RST_WCM;
      end else if (wr_hit) begin
         case (avs_address_i)
            `RLLS_IDX_SCRATCH:
               scratch_reg <= merge16(scratch_reg, avs_writedata_i[15:0], wr_lo, wr_hi);
            `RLLS_IDX_IRQCTL:
               irqctl_reg <= merge16(irqctl_reg, avs_writedata_i[15:0], wr_lo, wr_hi)
                             & `RLLS_MSK_IRQCTL;
            `RLLS_IDX_RECCTL:
               recctl_reg <= merge16(recctl_reg, avs_writedata_i[15:0], wr_lo, wr_hi);
            `RLLS_IDX_TRAINCFG: begin
               traincfg_reg <= merge16(traincfg_reg, avs_writedata_i[15:0], wr_lo, wr_hi)
                               & `RLLS_MSK_TRAINCFG;
               if (avs_byteenable_i[2])
                  wcm_reg <= avs_writedata_i[17:16];
            end
            default: begin
            end
         endcase
      end
   end

   // ******************************************
   // read mux and bus handshake
   // ******************************************
   always @* begin
      case (avs_address_i)
         `RLLS_IDX_SCRATCH:  rdata = scratch_reg;
         `RLLS_IDX_STATUS:   rdata = {alive_reg, 12'h000, sticky_reg} | `RLLS_STS_RSV;
         `RLLS_IDX_IRQCTL:   rdata = irqctl_reg;
         `RLLS_IDX_RECCTL:   rdata = recctl_reg;
         `RLLS_IDX_TRAINCFG: rdata = {traincfg_reg[15:7], data_lock_lost_live_o,
                                      ref_lost_s, det_int, traincfg_reg[3:0]};
         default:            rdata = 16'h0000;
      endcase
   end

   // answer one cycle after the request, then release
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg           <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h00000000;
      end else begin
         acc_reg           <= (avs_read_i || avs_write_i) && !acc_reg;
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !acc_reg);
         if (avs_read_i && !acc_reg)
            avs_readdata_o <= {14'h0000,
                               (avs_address_i == `RLLS_IDX_TRAINCFG) ? wcm_reg : 2'h0,
                               rdata};
      end
   end

   // ******************************************
   // registered outputs
   // ******************************************
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o                       <= 1'b0;
         detect_active_o             <= 1'b0;
         train_to_ref_o              <= 1'b1;
         serial_diag_loopback_o      <= 1'b0;
         slice_one_rx_enable_o       <= 1'b0;
         recovery_unit_enable_o      <= 1'b0;
         high_rate_receiver_enable_o <= 1'b0;
         recovery_unit_reset_o       <= 1'b0;
         slice_one_data_o            <= 1'b0;
         data_lock_lost_live_o       <= 1'b1;
      end else begin
         irq_o <= |(sticky_next & irqctl_reg[2:0]);
         detect_active_o        <= det_int;
         train_to_ref_o         <= !det_int;
         serial_diag_loopback_o <= recctl_reg[`RLLS_B_LOOPBACK];
         slice_one_rx_enable_o  <= recctl_reg[`RLLS_B_SLICE1];
         slice_one_data_o       <= recctl_reg[`RLLS_B_SLICE1] & rx_bit_s;
         recovery_unit_enable_o <= recctl_reg[`RLLS_B_REC_EN] &
                                   !recctl_reg[`RLLS_B_REC_RST];
         high_rate_receiver_enable_o <= recctl_reg[`RLLS_B_RX_EN];
         recovery_unit_reset_o  <= recctl_reg[`RLLS_B_REC_RST];
         data_lock_lost_live_o  <= set_cond[`RLLS_B_DATA_LOCK];
      end
   end

endmodule
